// file: verilog/vis_pkg.sv
// package: register map, field positions, reset values and timing for input supervision
package vis_pkg;

   // ****************************************
   // clock and time base
   // ****************************************
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam logic [15:0] DIFF_BLOCK_MS = 16'h0014;
   localparam logic [15:0] POWER_CYCLE_MS = 16'h0014;

   // ****************************************
   // register byte addresses
   // ****************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_VTS_DELAY = 8'h04;
   localparam logic [7:0] ADDR_CTS_DELAY = 8'h08;
   localparam logic [7:0] ADDR_RESTRAINT = 8'h0c;
   localparam logic [7:0] ADDR_END_SEL = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;

   // ****************************************
   // control fields
   // ****************************************
   localparam int unsigned CTRL_VTS_BLOCK = 0;
   localparam int unsigned CTRL_VTS_AUTO = 1;
   localparam int unsigned CTRL_XFORMER = 2;
   localparam int unsigned CTRL_CTS_RESTRAIN = 3;
   localparam int unsigned CTRL_VTS_RESET = 4;
   localparam logic [3:0] CTRL_RESET_VAL = 4'h3;

   // ****************************************
   // end select fields, status and interrupt bits
   // ****************************************
   localparam int unsigned SEL_REF_LSB = 0;
   localparam int unsigned SEL_DEF_LSB = 3;
   localparam int unsigned SEL_NEG_LSB = 6;
   localparam int unsigned STAT_END_LSB = 8;
   localparam int unsigned EV_VTS_COND = 0;
   localparam int unsigned EV_VTS_ALARM = 1;
   localparam int unsigned EV_CTS_FAIL = 2;
   localparam int unsigned EV_CTS_ALARM = 3;
   localparam int unsigned NUM_EVENTS = 4;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [15:0] VTS_DELAY_RESET = 16'h1388;
   localparam logic [15:0] CTS_DELAY_RESET = 16'h2710;
   localparam logic [15:0] RESTRAINT_RESET = 16'h0000;
   localparam logic [8:0] END_SEL_RESET = 9'h000;

endpackage

// file: verilog/vis_supervision.sv
// module: voltage and current input supervision with apb registers and interrupt
//
// Behaviour
// [RQ1] negative-sequence voltage without current flags failure
// [RQ2] all voltages absent, no current change
// [RQ3] overcurrent inhibit detectors suppress voltage block
// [RQ4] action select: block protection or alarm only
// [RQ5] reset select: manual or automatic clearing
// [RQ6] alarm after operate delay, condition continuous
// [RQ7] voltage supervision inhibited while all poles dead
// [RQ8] current change within one cycle inhibits
// [RQ9] current supervision only with transformer winding option
// [RQ10] high ratio at every end means fault
// [RQ11] release current at one end blocks
// [RQ12] indication: zero delay alarm, no restraint
// [RQ13] restraint: block 20 ms, then enlarge bias
// [RQ14] earth and negseq functions blocked on failed input
// [RQ15] monitor sequence currents of 2 to 5 inputs
// [RQ16] fault needs release, high end, others low
// [RQ17] symmetrical three-phase failure not detected
// [RQ18] current alarm after supervision delay expires
// [RQ19] auto clears on condition loss, manual latches
`timescale 1ns/10ps
`default_nettype none
module vis_supervision #(
   parameter int unsigned NUM_ENDS = 5,
   parameter int unsigned TICK_CYCLES = vis_pkg::TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic negseq_v_detect,
   input wire logic negseq_i_detect,
   input wire logic [2:0] phase_v_absent,
   input wire logic [2:0] phase_i_change,
   input wire logic phase_overcurrent_inhibit_level,
   input wire logic negseq_overcurrent_inhibit_level,
   input wire logic all_poles_dead,
   input wire logic [NUM_ENDS-1:0] posseq_above_release,
   input wire logic [NUM_ENDS-1:0] ratio_above_high,
   input wire logic [NUM_ENDS-1:0] ratio_below_low,
   output logic voltage_sup_operate_out,
   output logic voltage_sup_alarm,
   output logic current_sup_alarm,
   output logic diff_block,
   output logic [15:0] restraint_region_increase,
   output logic ref_block,
   output logic derived_ef_block,
   output logic negseq_oc_block,
   output logic irq
);
   import vis_pkg::*;

   // ****************************************
   // functions
   // ****************************************
   // an index past the last end selects nothing
   function automatic logic end_pick(input logic [NUM_ENDS-1:0] v, input logic [2:0] sel);
      return (32'(sel) < NUM_ENDS) ? v[sel] : 1'b0;
   endfunction

   // ****************************************
   // registers and apb slave
   // ****************************************
   logic [3:0] ctrl_q;
   logic [15:0] vts_delay_q;
   logic [15:0] cts_delay_q;
   logic [15:0] restraint_q;
   logic [8:0] end_sel_q;
   logic [NUM_EVENTS-1:0] irq_status_q;
   logic [NUM_EVENTS-1:0] irq_mask_q;
   logic vts_reset_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic wr_en;
   logic rd_en;
   logic addr_ok;
   logic [31:0] rd_data;
   logic [31:0] status_word;
   logic [NUM_EVENTS-1:0] events;

   // one wait state: ready comes from a flop in the second access cycle
   assign wr_en = psel & penable & pready_q & pwrite & addr_ok;
   assign rd_en = psel & penable & ~pready_q;

   always_comb begin
      addr_ok = 1'b1;
      rd_data = 32'h0000_0000;
      unique case (paddr)
         ADDR_CTRL: rd_data = {28'h0000000, ctrl_q};
         ADDR_VTS_DELAY: rd_data = {16'h0000, vts_delay_q};
         ADDR_CTS_DELAY: rd_data = {16'h0000, cts_delay_q};
         ADDR_RESTRAINT: rd_data = {16'h0000, restraint_q};
         ADDR_END_SEL: rd_data = {23'h000000, end_sel_q};
         ADDR_STATUS: rd_data = status_word;
         ADDR_IRQ_STATUS: rd_data = {28'h0000000, irq_status_q};
         ADDR_IRQ_MASK: rd_data = {28'h0000000, irq_mask_q};
         default: addr_ok = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         if (rd_en) begin
            pslverr_q <= ~addr_ok;
            prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET_VAL;
         vts_delay_q <= VTS_DELAY_RESET;
         cts_delay_q <= CTS_DELAY_RESET;
         restraint_q <= RESTRAINT_RESET;
         end_sel_q <= END_SEL_RESET;
         irq_mask_q <= '0;
      end else if (wr_en) begin
         unique case (paddr)
            ADDR_CTRL: ctrl_q <= pwdata[3:0];
            ADDR_VTS_DELAY: vts_delay_q <= pwdata[15:0];
            ADDR_CTS_DELAY: cts_delay_q <= pwdata[15:0];
            ADDR_RESTRAINT: restraint_q <= pwdata[15:0];
            ADDR_END_SEL: end_sel_q <= pwdata[8:0];
            ADDR_IRQ_MASK: irq_mask_q <= pwdata[NUM_EVENTS-1:0];
            default: ;
         endcase
      end
   end

   // manual reset command is a self-clearing write pulse
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         vts_reset_q <= 1'b0;
      end else begin
         vts_reset_q <= wr_en && paddr == ADDR_CTRL && pwdata[CTRL_VTS_RESET];
      end
   end

   // ****************************************
   // millisecond time base
   // ****************************************
   logic [31:0] tick_cnt_q;
   logic tick_q;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q <= 1'b0;
      end else if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
         tick_q <= 1'b0;
      end
   end

   // ****************************************
   // voltage input supervision
   // ****************************************
   logic [15:0] change_win_q;
   logic change_active;
   logic vts_raw;
   logic vts_inhibit;
   logic vts_cond;
   logic vts_detect_q;
   logic [15:0] vts_timer_q;
   logic vts_expired;
   logic vts_alarm_q;
   logic vts_block_q;

   // stretch any current step over one power cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         change_win_q <= 16'h0000;
      end else if (|phase_i_change) begin
         change_win_q <= POWER_CYCLE_MS; // [RQ8]
      end else if (tick_q && change_win_q != 16'h0000) begin
         change_win_q <= change_win_q - 16'h0001;
      end
   end

   assign change_active = (|phase_i_change) | (change_win_q != 16'h0000);
   assign vts_raw = (negseq_v_detect & ~negseq_i_detect) | // [RQ1]
                    ((&phase_v_absent) & ~change_active); // [RQ2]
   assign vts_inhibit = phase_overcurrent_inhibit_level | negseq_overcurrent_inhibit_level | // [RQ3]
                        all_poles_dead | // [RQ7]
                        change_active; // [RQ8]
   assign vts_cond = vts_raw & ~vts_inhibit;

   // timer restarts whenever the condition drops, so only a continuous failure alarms
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         vts_timer_q <= 16'h0000;
      end else if (!vts_cond) begin
         vts_timer_q <= 16'h0000;
      end else if (tick_q && !vts_expired) begin
         vts_timer_q <= vts_timer_q + 16'h0001; // [RQ6]
      end
   end

   assign vts_expired = vts_cond && vts_timer_q >= vts_delay_q;

   // set wins over a manual reset arriving in the same cycle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         vts_detect_q <= 1'b0;
         vts_alarm_q <= 1'b0;
      end else if (ctrl_q[CTRL_VTS_AUTO]) begin
         vts_detect_q <= vts_cond; // [RQ5] [RQ19]
         vts_alarm_q <= vts_expired;
      end else begin
         vts_detect_q <= vts_cond | (vts_detect_q & ~vts_reset_q); // [RQ19]
         vts_alarm_q <= vts_expired | (vts_alarm_q & ~vts_reset_q);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         vts_block_q <= 1'b0;
      end else begin
         vts_block_q <= vts_detect_q & ctrl_q[CTRL_VTS_BLOCK]; // [RQ4]
      end
   end

   // ****************************************
   // current input supervision
   // ****************************************
   logic cts_enable;
   logic [3:0] release_count;
   logic [NUM_ENDS-1:0] cand;
   logic cts_fault;
   logic cts_fail_q;
   logic [NUM_ENDS-1:0] fail_end_q;
   logic [15:0] cts_timer_q;
   logic cts_alarm_q;
   logic [15:0] diff_timer_q;
   logic diff_block_q;
   logic [15:0] restraint_out_q;
   logic [2:0] prot_block_q;

   assign cts_enable = ctrl_q[CTRL_XFORMER]; // [RQ9]
   assign release_count = 4'($countones(posseq_above_release)); // [RQ15]

   // an end is a candidate when it sees the high ratio and every other end is low or below release
   generate
      for (genvar g = 0; g < NUM_ENDS; g++) begin : g_cand
         logic [NUM_ENDS-1:0] others_quiet;
         always_comb begin
            others_quiet = ratio_below_low | ~posseq_above_release; // [RQ16]
            others_quiet[g] = 1'b1;
         end
         assign cand[g] = ratio_above_high[g] & (&others_quiet);
      end
   endgenerate

   // a balanced loss of all three phases gives no negative sequence, so it goes unseen
   assign cts_fault = cts_enable &
                      (release_count >= 4'h2) & // [RQ11] [RQ16]
                      ~(&ratio_above_high) & // [RQ10]
                      (|cand); // [RQ17]

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cts_fail_q <= 1'b0;
         fail_end_q <= '0;
      end else begin
         cts_fail_q <= cts_fault;
         fail_end_q <= cts_fault ? cand : '0;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cts_timer_q <= 16'h0000;
         cts_alarm_q <= 1'b0;
      end else if (!cts_fail_q) begin
         cts_timer_q <= 16'h0000;
         cts_alarm_q <= 1'b0;
      end else if (!ctrl_q[CTRL_CTS_RESTRAIN]) begin
         cts_alarm_q <= 1'b1; // [RQ12]
      end else if (cts_timer_q >= cts_delay_q) begin
         cts_alarm_q <= 1'b1; // [RQ18]
      end else if (tick_q) begin
         cts_timer_q <= cts_timer_q + 16'h0001;
      end
   end

   // restraint: hard block first, then widened bias while the failure stands
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         diff_timer_q <= 16'h0000;
         diff_block_q <= 1'b0;
         restraint_out_q <= 16'h0000;
      end else if (!cts_fail_q || !ctrl_q[CTRL_CTS_RESTRAIN]) begin
         diff_timer_q <= 16'h0000;
         diff_block_q <= 1'b0; // [RQ12]
         restraint_out_q <= 16'h0000;
      end else if (diff_timer_q < DIFF_BLOCK_MS) begin
         diff_block_q <= 1'b1; // [RQ13]
         if (tick_q) begin
            diff_timer_q <= diff_timer_q + 16'h0001;
         end
      end else begin
         diff_block_q <= 1'b0;
         restraint_out_q <= restraint_q; // [RQ13]
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         prot_block_q <= 3'h0;
      end else begin
         prot_block_q[0] <= end_pick(fail_end_q, end_sel_q[SEL_REF_LSB +: 3]); // [RQ14]
         prot_block_q[1] <= end_pick(fail_end_q, end_sel_q[SEL_DEF_LSB +: 3]); // [RQ14]
         prot_block_q[2] <= end_pick(fail_end_q, end_sel_q[SEL_NEG_LSB +: 3]); // [RQ14]
      end
   end

   // ****************************************
   // status and interrupt
   // ****************************************
   logic [NUM_EVENTS-1:0] stat_now;
   logic [NUM_EVENTS-1:0] stat_d1_q;
   logic irq_q;
   logic [NUM_EVENTS-1:0] w1c;

   // bits in event order, so a rising status bit is its own event
   assign stat_now = {cts_alarm_q, cts_fail_q, vts_alarm_q, vts_detect_q};
   assign status_word = {{(24 - NUM_ENDS){1'b0}}, fail_end_q, 4'h0, stat_now};
   assign events = stat_now & ~stat_d1_q;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         stat_d1_q <= '0;
      end else begin
         stat_d1_q <= stat_now;
      end
   end

   assign w1c = (wr_en && paddr == ADDR_IRQ_STATUS) ? pwdata[NUM_EVENTS-1:0] : '0;

   // a new event in the clearing cycle survives the clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         irq_status_q <= '0;
         irq_q <= 1'b0;
      end else begin
         irq_status_q <= events | (irq_status_q & ~w1c);
         irq_q <= |((events | (irq_status_q & ~w1c)) & irq_mask_q);
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign voltage_sup_operate_out = vts_block_q;
   assign voltage_sup_alarm = vts_alarm_q;
   assign current_sup_alarm = cts_alarm_q;
   assign diff_block = diff_block_q;
   assign restraint_region_increase = restraint_out_q;
   assign ref_block = prot_block_q[0];
   assign derived_ef_block = prot_block_q[1];
   assign negseq_oc_block = prot_block_q[2];
   assign irq = irq_q;

endmodule
`default_nettype wire

// file: verification/vis_supervision_checker.sv
// checker: port-level properties of the input supervision block
`timescale 1ns/10ps
`default_nettype none
module vis_supervision_checker #(
   parameter int unsigned NUM_ENDS = 5,
   parameter int unsigned TICK_CYCLES = vis_pkg::TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic negseq_v_detect,
   input wire logic [2:0] phase_v_absent,
   input wire logic phase_overcurrent_inhibit_level,
   input wire logic all_poles_dead,
   input wire logic [NUM_ENDS-1:0] posseq_above_release,
   input wire logic [NUM_ENDS-1:0] ratio_above_high,
   input wire logic voltage_sup_operate_out,
   input wire logic diff_block,
   input wire logic [15:0] restraint_region_increase,
   input wire logic ref_block,
   input wire logic negseq_oc_block
);
   // one tick of slack: the ms prescaler runs free
   localparam int unsigned MAX_BLOCK = 21 * TICK_CYCLES + 3;
   int unsigned blk_cnt;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         blk_cnt <= '0;
      end else begin
         blk_cnt <= diff_block ? blk_cnt + 1 : '0;
      end
   end
   // ****************************************
   // properties
   // ****************************************
   chk_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("ready not after one wait state");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   chk_err_unmapped: assert property (pready && paddr > 8'h1c |-> pslverr)
      else $error("no error on unmapped address");
   chk_write_rdata: assert property (pready && pwrite |-> prdata == 32'h0)
      else $error("write returned data");
   chk_operate_cause: assert property (
      $rose(voltage_sup_operate_out) |->
      $past(negseq_v_detect, 2) || $past(phase_v_absent, 2) == 3'h7)
      else $error("voltage block without cause");
   chk_operate_inhibit: assert property (
      $rose(voltage_sup_operate_out) |->
      !$past(all_poles_dead, 2) && !$past(phase_overcurrent_inhibit_level, 2))
      else $error("voltage block while inhibited");
   chk_block_span: assert property (blk_cnt <= MAX_BLOCK)
      else $error("differential block too long");
   chk_block_bias: assert property (diff_block |-> restraint_region_increase == 16'h0)
      else $error("bias raised during block");
   chk_all_high_quiet: assert property (
      (&ratio_above_high)[*4] |-> !ref_block && !negseq_oc_block)
      else $error("input failure on balanced fault");
   chk_single_release: assert property (
      ($countones(posseq_above_release) < 2)[*4] |-> !ref_block && !negseq_oc_block)
      else $error("input failure with one end fed");
endmodule
`default_nettype wire

// file: verification/vis_front_model.sv
// model: measurement comparators and pole-dead feed ahead of the supervision block
`timescale 1ns/10ps
`default_nettype none
module vis_front_model #(
   parameter int unsigned NUM_ENDS = 5
) (
   input wire logic mclk,
   input wire logic [2:0] vmode,
   input wire logic [1:0] cmode,
   output logic negseq_v_detect,
   output logic negseq_i_detect,
   output logic [2:0] phase_v_absent,
   output logic [2:0] phase_i_change,
   output logic phase_overcurrent_inhibit_level,
   output logic negseq_overcurrent_inhibit_level,
   output logic all_poles_dead,
   output logic [NUM_ENDS-1:0] posseq_above_release,
   output logic [NUM_ENDS-1:0] ratio_above_high,
   output logic [NUM_ENDS-1:0] ratio_below_low
);
   // the failed input is always end 1
   localparam logic [NUM_ENDS-1:0] ONE = NUM_ENDS'(2);
   logic [2:0] vmode_q = 3'h0;
   always @(posedge mclk) begin
      vmode_q <= vmode;
   end
   always_comb begin
      negseq_v_detect = vmode inside {3'h1, 3'h2, 3'h6, 3'h7};
      negseq_i_detect = vmode == 3'h2;
      phase_v_absent = (vmode inside {3'h3, 3'h4, 3'h5}) ? 3'h7 : 3'h0;
      // a step is seen only once, as the line is energised
      phase_i_change = (vmode == 3'h4 && vmode_q != 3'h4) ? 3'h5 : 3'h0;
      phase_overcurrent_inhibit_level = vmode == 3'h5;
      negseq_overcurrent_inhibit_level = vmode == 3'h7;
      all_poles_dead = vmode == 3'h6;
      posseq_above_release = (cmode == 2'h3) ? ONE : '1;
      ratio_above_high = (cmode == 2'h0) ? '0 : (cmode == 2'h2) ? '1 : ONE;
      ratio_below_low = (cmode == 2'h0) ? '1 : (cmode == 2'h2) ? '0 : ~ONE;
   end
endmodule
`default_nettype wire

// file: verification/vis_supervision_bench.sv
// testbench: directed scenarios for the input supervision block
`timescale 1ns/10ps
`default_nettype none
module vis_supervision_bench;
   import vis_pkg::*;
   logic mclk = 1'h0;
   logic rst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [2:0] vmode = 3'h0;
   logic [1:0] cmode = 2'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, er, nv, ni, poi, noi, apd, eb, nb;
   // operate, v alarm, c alarm, diff block, irq, ref block
   wire [5:0] mon;
   logic [2:0] va, ic;
   logic [4:0] rel, hi, lo;
   logic [15:0] rr;
   int n_mismatch = 0;
   int tests_run = 0;
   always #10 mclk = ~mclk;
   vis_front_model u_vis_front_model (.mclk(mclk), .vmode(vmode), .cmode(cmode),
      .negseq_v_detect(nv), .negseq_i_detect(ni), .phase_v_absent(va), .phase_i_change(ic),
      .phase_overcurrent_inhibit_level(poi), .negseq_overcurrent_inhibit_level(noi),
      .all_poles_dead(apd), .posseq_above_release(rel), .ratio_above_high(hi),
      .ratio_below_low(lo));
   // 10-clock ms tick: the 20 ms block spans 200 cycles
   vis_supervision #(.NUM_ENDS(5), .TICK_CYCLES(10)) u_vis_supervision (.mclk(mclk),
      .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .negseq_v_detect(nv), .negseq_i_detect(ni), .phase_v_absent(va), .phase_i_change(ic),
      .phase_overcurrent_inhibit_level(poi), .negseq_overcurrent_inhibit_level(noi),
      .all_poles_dead(apd), .posseq_above_release(rel), .ratio_above_high(hi),
      .ratio_below_low(lo), .voltage_sup_operate_out(mon[0]), .voltage_sup_alarm(mon[1]),
      .current_sup_alarm(mon[2]), .diff_block(mon[3]), .restraint_region_increase(rr),
      .ref_block(mon[5]), .derived_ef_block(eb), .negseq_oc_block(nb), .irq(mon[4]));
   // ****************************************
   // helpers
   // ****************************************
   task automatic test_done;
      $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s", $time, m);
      end
   endtask
   // call just after a rising edge; one idle edge follows each transfer
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'h1;
      for (i = 0; i < 20; i++) begin
         @(posedge mclk);
         if (pready === 1'h1) break;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge mclk);
      if (i == 20) begin
         chk(32'h0, 32'h1, "apb timeout");
         test_done;
      end
   endtask
   // hold: value must stand n cycles; else: must appear within n cycles
   task automatic obs(input int s, input logic v, input int n, input bit hold, input string m);
      int i;
      logic ok;
      ok = hold;
      for (i = 0; i < n && (hold || !ok); i++) begin
         @(negedge mclk);
         if (hold && mon[s] !== v) ok = 1'h0;
         if (!hold && mon[s] === v) ok = 1'h1;
      end
      @(posedge mclk);
      chk({31'h0, ok}, 32'h1, m);
      if (!ok && !hold) test_done;
   endtask
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_regs;
      apb(1'h0, ADDR_CTRL, 32'h0);
      chk(rd, 32'h3, "ctrl reset");
      apb(1'h0, ADDR_VTS_DELAY, 32'h0);
      chk(rd, {16'h0, VTS_DELAY_RESET}, "vts delay reset");
      apb(1'h0, ADDR_CTS_DELAY, 32'h0);
      chk(rd, {16'h0, CTS_DELAY_RESET}, "cts delay reset");
      apb(1'h1, 8'h20, 32'h5);
      chk({31'h0, er}, 32'h1, "unmapped error");
      $display("test regs done");
   endtask
   task automatic t_vts_block;
      apb(1'h1, ADDR_VTS_DELAY, 32'h3);
      apb(1'h1, ADDR_IRQ_MASK, 32'h1);
      vmode <= 3'h1;
      obs(0, 1'h1, 6, 1'b0, "block on negseq voltage");
      obs(1, 1'h0, 12, 1'b1, "alarm early");
      obs(1, 1'h1, 60, 1'b0, "alarm after delay");
      chk({31'h0, mon[4]}, 32'h1, "irq raised");
      vmode <= 3'h0;
      obs(0, 1'h0, 6, 1'b0, "auto clear");
      apb(1'h1, ADDR_IRQ_STATUS, 32'hf);
      obs(4, 1'h0, 3, 1'b0, "irq cleared");
      for (int m = 0; m < 4; m++) begin
         vmode <= 3'(m == 0 ? 2 : m + 4);
         obs(0, 1'h0, 30, 1'b1, "inhibited block");
      end
      vmode <= 3'h0;
      $display("test vts block done");
   endtask
   task automatic t_vts_three;
      apb(1'h1, ADDR_IRQ_MASK, 32'h0);
      vmode <= 3'h3;
      obs(0, 1'h1, 6, 1'b0, "three phase loss");
      chk({31'h0, mon[4]}, 32'h0, "irq masked");
      apb(1'h1, ADDR_IRQ_MASK, 32'h1);
      obs(4, 1'h1, 3, 1'b0, "irq unmasked");
      vmode <= 3'h0;
      apb(1'h1, ADDR_IRQ_STATUS, 32'hf);
      vmode <= 3'h4;
      obs(0, 1'h0, 150, 1'b1, "current step inhibits");
      obs(0, 1'h1, 120, 1'b0, "inhibit expires");
      vmode <= 3'h0;
      obs(0, 1'h0, 6, 1'b0, "three phase clear");
      $display("test vts three done");
   endtask
   task automatic t_vts_modes;
      apb(1'h1, ADDR_CTRL, 32'h2);
      vmode <= 3'h1;
      obs(0, 1'h0, 20, 1'b1, "alarm only, no block");
      obs(1, 1'h1, 60, 1'b0, "alarm only alarm");
      vmode <= 3'h0;
      apb(1'h1, ADDR_CTRL, 32'h1);
      vmode <= 3'h1;
      obs(0, 1'h1, 6, 1'b0, "manual block");
      vmode <= 3'h0;
      obs(0, 1'h1, 20, 1'b1, "manual latch");
      apb(1'h1, ADDR_CTRL, 32'h11);
      obs(0, 1'h0, 4, 1'b0, "manual reset");
      apb(1'h1, ADDR_CTRL, 32'h3);
      $display("test vts modes done");
   endtask
   task automatic t_cts_ind;
      apb(1'h1, ADDR_END_SEL, 32'h51);
      cmode <= 2'h1;
      obs(2, 1'h0, 20, 1'b1, "no xformer, no alarm");
      apb(1'h1, ADDR_CTRL, 32'h7);
      obs(2, 1'h1, 6, 1'b0, "indication alarm");
      chk({31'h0, mon[3]}, 32'h0, "indication unrestricted");
      obs(5, 1'h1, 3, 1'b0, "ref block");
      chk({30'h0, eb, nb}, 32'h1, "earth and negseq blocks");
      apb(1'h0, ADDR_STATUS, 32'h0);
      chk(rd & 32'h1f04, 32'h0204, "failed end status");
      cmode <= 2'h2;
      obs(2, 1'h0, 6, 1'b0, "balanced fault clears");
      obs(2, 1'h0, 20, 1'b1, "balanced fault quiet");
      cmode <= 2'h3;
      obs(2, 1'h0, 20, 1'b1, "single end fed");
      cmode <= 2'h0;
      $display("test cts indication done");
   endtask
   task automatic t_cts_res;
      apb(1'h1, ADDR_RESTRAINT, 32'h55);
      apb(1'h1, ADDR_CTS_DELAY, 32'h2);
      apb(1'h1, ADDR_CTRL, 32'hf);
      cmode <= 2'h1;
      obs(3, 1'h1, 6, 1'b0, "diff block");
      chk({31'h0, mon[2]}, 32'h0, "alarm waits delay");
      obs(3, 1'h1, 180, 1'b1, "diff block held");
      obs(3, 1'h0, 40, 1'b0, "diff block ends");
      chk({16'h0, rr}, 32'h55, "bias raised");
      chk({31'h0, mon[2]}, 32'h1, "alarm after delay");
      cmode <= 2'h0;
      $display("test cts restraint done");
   endtask
   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'h0;
      @(posedge mclk);
      t_regs;
      t_vts_block;
      t_vts_three;
      t_vts_modes;
      t_cts_ind;
      t_cts_res;
      test_done;
   end
endmodule
bind vis_supervision vis_supervision_checker #(.NUM_ENDS(NUM_ENDS), .TICK_CYCLES(TICK_CYCLES))
   u_vis_supervision_checker (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .negseq_v_detect(negseq_v_detect), .phase_v_absent(phase_v_absent),
   .phase_overcurrent_inhibit_level(phase_overcurrent_inhibit_level),
   .all_poles_dead(all_poles_dead), .posseq_above_release(posseq_above_release),
   .ratio_above_high(ratio_above_high), .voltage_sup_operate_out(voltage_sup_operate_out),
   .diff_block(diff_block), .restraint_region_increase(restraint_region_increase),
   .ref_block(ref_block), .negseq_oc_block(negseq_oc_block));
`default_nettype wire
